// file: src/pc_ac_pkg.sv
// constants for the program counter and accumulator control block
package pc_ac_pkg;

	// ****************************************************************
	// word layout
	// ****************************************************************
	localparam int WORD_W    = 18;
	localparam int PC_LO     = 5;
	localparam int PC_HI     = 17;
	localparam int PC_W      = PC_HI - PC_LO + 1;

	// operate microcode bit positions, bit 0 is the msb
	localparam int OPR_INVERT_BIT   = 8;
	localparam int OPR_LINK_BIT     = 9;
	localparam int OPR_ZERO_BIT     = 10;
	localparam int OPR_NEG_BIT      = 11;
	localparam int OPR_ACS_BIT      = 15;
	localparam int SIGN_BIT         = 0;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS    = 10;
	localparam int INC_DELAY_NS     = 20;
	localparam int INC_DELAY_CYCLES = (INC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// apb register map
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ACC_SWITCH_ADDR  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SWITCH_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] ACCUM_ADDR       = 8'h08;
	localparam logic [ADDR_W-1:0] PC_ADDR          = 8'h0C;
	localparam logic [ADDR_W-1:0] FLAGS_ADDR       = 8'h10;

	localparam logic [WORD_W-1:0] ACC_SWITCH_RESET  = 18'h00000;
	localparam logic [PC_W-1:0]   ADDR_SWITCH_RESET = 13'h0000;
	localparam logic [PC_W-1:0]   PC_RESET          = 13'h0000;

	// flags register fields
	localparam int FLAG_LINK = 0;
	localparam int FLAG_POV  = 1;
	localparam int FLAG_OVF  = 2;
	localparam int FLAG_SKIP = 3;
	localparam int FLAG_ZERO = 4;
	localparam int FLAG_W    = 5;

endpackage : pc_ac_pkg

// file: src/pc_and_accumulator_control.sv
// program counter and accumulator control of an 18-bit processor
//
// Summary of operation
// - deposit keys load accumulator switches at SP2
// - operate bit 15 loads switches at T7
// - T4 of add sets possible overflow flag when ac0 zero
// - overflow when flag, mb0 one, ac0 zero
// - overflow sets link at next TP1
// - T1 clears the possible overflow flag
// - bit 8 clear: skip link, zero, negative
// - bit 8 set: tests inverted
// - combine by OR, or AND when inverted
// - skip increments program counter at T5
// - zero indication when all accumulator bits zero
// - clear touches only pc bits 5 to 17
// - pc clear on keys, jump, subroutine, break, readin
// - address switches load pc at SP2
// - jump fetch T6 loads mb into pc
// - subroutine or break T4 loads ma into pc
// - fetch increment follows pc copy by 20 ns
// - increment at tape SP2 and key SP4
// - fetch T1 copies pc into ma
`timescale 1ns/1ps
`default_nettype none

module pc_and_accumulator_control
	import pc_ac_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// timing pulses
	input  wire logic                t1,
	input  wire logic                t3,
	input  wire logic                t4,
	input  wire logic                t5,
	input  wire logic                t6,
	input  wire logic                t7,
	input  wire logic                tp1,
	input  wire logic                sp1,
	input  wire logic                sp2,
	input  wire logic                sp4,
	// major states and keys
	input  wire logic                fetch_state,
	input  wire logic                execute_state,
	input  wire logic                break_state,
	input  wire logic                key_start,
	input  wire logic                key_examine,
	input  wire logic                key_deposit,
	input  wire logic                key_deposit_next,
	input  wire logic                readin,
	input  wire logic                repeat_flag,
	input  wire logic                read_tape,
	// instruction decode
	input  wire logic                operate_instruction,
	input  wire logic                jump_instruction,
	input  wire logic                subroutine_jump_instruction,
	input  wire logic                add_instruction,
	// datapath
	input  wire logic [0:WORD_W-1]   memory_buffer_register,
	input  wire logic [0:WORD_W-1]   accumulator_register,
	input  wire logic [PC_LO:PC_HI]  memory_address_register,
	input  wire logic                link_bit,
	// commands and state out
	output logic                     ac_load_switches,
	output logic      [0:WORD_W-1]   ac_load_data,
	output logic                     link_set,
	output logic                     pc_to_ma,
	output logic      [PC_LO:PC_HI]  ma_load_data,
	output logic      [PC_LO:PC_HI]  program_counter,
	output logic                     possible_overflow_flag,
	output logic                     add_overflow_level,
	output logic                     operate_skip_level,
	output logic                     ac_zero,
	output logic                     ac_nonzero
);

	// ****************************************************************
	// apb registers
	// ****************************************************************
	logic [0:WORD_W-1]   console_accumulator_switches;
	logic [PC_LO:PC_HI]  console_address_switches;
	logic [FLAG_W-1:0]   flags;
	wire                 apb_access = psel && penable;
	wire                 apb_write  = apb_access && pwrite;
	wire                 hit_acs    = (paddr == ACC_SWITCH_ADDR);
	wire                 hit_as     = (paddr == ADDR_SWITCH_ADDR);
	wire                 hit_ac     = (paddr == ACCUM_ADDR);
	wire                 hit_pc     = (paddr == PC_ADDR);
	wire                 hit_flags  = (paddr == FLAGS_ADDR);
	wire                 hit_any    = hit_acs || hit_as || hit_ac || hit_pc || hit_flags;

	assign pready  = 1'b1;
	assign pslverr = apb_access && !hit_any;
	assign flags   = {ac_zero, operate_skip_level, add_overflow_level,
		possible_overflow_flag, link_bit};
	assign prdata  = !(psel && !pwrite) ? 32'h00000000 :
		hit_acs   ? {14'h0000, console_accumulator_switches} :
		hit_as    ? {19'h00000, console_address_switches} :
		hit_ac    ? {14'h0000, accumulator_register} :
		hit_pc    ? {19'h00000, program_counter} :
		hit_flags ? {27'h0000000, flags} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			console_accumulator_switches <= ACC_SWITCH_RESET;
			console_address_switches     <= ADDR_SWITCH_RESET;
		end else begin
			if (apb_write && hit_acs)
				console_accumulator_switches <= pwdata[WORD_W-1:0];
			if (apb_write && hit_as)
				console_address_switches <= pwdata[PC_W-1:0];
		end
	end

	// ****************************************************************
	// accumulator switch loading
	// ****************************************************************
	wire key_deposit_any = key_deposit || key_deposit_next;
	wire opr_acs_load    = t7 && operate_instruction && memory_buffer_register[OPR_ACS_BIT];

	assign ac_load_switches = (sp2 && key_deposit_any) || opr_acs_load;
	assign ac_load_data     = console_accumulator_switches;

	// ****************************************************************
	// add overflow into link
	// ****************************************************************
	wire pov_set = t4 && add_instruction && !accumulator_register[SIGN_BIT];

	assign add_overflow_level = possible_overflow_flag && add_instruction
		&& memory_buffer_register[SIGN_BIT] && !accumulator_register[SIGN_BIT];
	assign link_set = tp1 && add_overflow_level;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			possible_overflow_flag <= 1'b0;
		else if (t1)
			possible_overflow_flag <= 1'b0;
		else if (pov_set)
			possible_overflow_flag <= 1'b1;
	end

	// ****************************************************************
	// operate skip decode
	// ****************************************************************
	assign ac_zero    = (accumulator_register == 18'h00000);
	assign ac_nonzero = !ac_zero;

	wire       skip_invert = memory_buffer_register[OPR_INVERT_BIT];
	wire [2:0] skip_select = {memory_buffer_register[OPR_LINK_BIT],
		memory_buffer_register[OPR_ZERO_BIT], memory_buffer_register[OPR_NEG_BIT]};
	wire [2:0] skip_test   = {link_bit, ac_zero, accumulator_register[SIGN_BIT]};
	wire       skip_or     = |(skip_select & skip_test);
	wire       skip_and    = &(~skip_select | ~skip_test);

	assign operate_skip_level = operate_instruction && (skip_invert ? skip_and : skip_or);

	// ****************************************************************
	// program counter commands
	// ****************************************************************
	logic [INC_DELAY_CYCLES-1:0] fetch_inc_pending;
	logic [PC_LO:PC_HI]          next_pc;

	wire key_sed      = key_start || key_examine || key_deposit;
	wire readin_load  = readin && !repeat_flag;
	wire jms_or_break = (execute_state && subroutine_jump_instruction) || break_state;
	wire jump_fetch   = fetch_state && jump_instruction;

	wire pc_clear = (sp1 && (key_sed || readin_load))
		|| (t5 && jump_fetch) || (t3 && jms_or_break);
	wire pc_load_switches = sp2 && (key_sed || readin_load);
	wire pc_load_mb       = t6 && jump_fetch;
	wire pc_load_ma       = t4 && jms_or_break;
	wire pc_increment     = fetch_inc_pending[INC_DELAY_CYCLES-1]
		|| (t5 && operate_skip_level)
		|| (sp2 && read_tape) || (sp4 && (key_examine || key_deposit));

	assign pc_to_ma     = t1 && fetch_state;
	assign ma_load_data = program_counter;

	// clear first, then or in transfers, then count; only bits 5 to 17
	always_comb begin
		next_pc = pc_clear ? PC_RESET : program_counter;
		if (pc_load_switches)
			next_pc = next_pc | console_address_switches;
		if (pc_load_mb)
			next_pc = next_pc | memory_buffer_register[PC_LO:PC_HI];
		if (pc_load_ma)
			next_pc = next_pc | memory_address_register;
		if (pc_increment)
			next_pc = next_pc + 13'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter   <= PC_RESET;
			fetch_inc_pending <= '0;
		end else begin
			program_counter   <= next_pc;
			fetch_inc_pending <= {fetch_inc_pending[INC_DELAY_CYCLES-2:0], pc_to_ma};
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	wire only_clear = pc_clear && !pc_load_switches && !pc_load_mb
		&& !pc_load_ma && !pc_increment;
	wire only_mb    = pc_load_mb && !pc_clear && !pc_load_switches
		&& !pc_load_ma && !pc_increment;
	wire only_ma    = pc_load_ma && !pc_clear && !pc_load_switches
		&& !pc_load_mb && !pc_increment;

	a_deposit_load: assert property (@(posedge pclk) disable iff (!presetn)
		(sp2 && key_deposit_any) |-> ac_load_switches
			&& ac_load_data == console_accumulator_switches)
		else $error("deposit key did not load accumulator switches");

	a_opr_switch_load: assert property (@(posedge pclk) disable iff (!presetn)
		ac_load_switches |-> (sp2 && key_deposit_any) || opr_acs_load)
		else $error("accumulator switch load without cause");

	a_pov_set: assert property (@(posedge pclk) disable iff (!presetn)
		(t4 && add_instruction && !accumulator_register[SIGN_BIT] && !t1)
			|=> possible_overflow_flag)
		else $error("possible overflow flag not set at add T4");

	a_overflow_cause: assert property (@(posedge pclk) disable iff (!presetn)
		add_overflow_level |-> possible_overflow_flag && memory_buffer_register[SIGN_BIT]
			&& !accumulator_register[SIGN_BIT])
		else $error("overflow declared without its conditions");

	a_link_set: assert property (@(posedge pclk) disable iff (!presetn)
		tp1 |-> (link_set == add_overflow_level))
		else $error("link set does not follow overflow at TP1");

	a_pov_clear: assert property (@(posedge pclk) disable iff (!presetn)
		t1 |=> !possible_overflow_flag)
		else $error("possible overflow flag not cleared by T1");

	a_skip_plain: assert property (@(posedge pclk) disable iff (!presetn)
		(operate_instruction && !skip_invert && skip_select == 3'b011)
			|-> operate_skip_level == (ac_zero || accumulator_register[SIGN_BIT]))
		else $error("non inverted skip combine wrong");

	a_skip_inverted: assert property (@(posedge pclk) disable iff (!presetn)
		(operate_instruction && skip_invert && skip_select == 3'b101)
			|-> operate_skip_level == (!link_bit && !accumulator_register[SIGN_BIT]))
		else $error("inverted skip combine wrong");

	a_ac_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(ac_zero == (accumulator_register == 18'h00000)) && (ac_nonzero != ac_zero))
		else $error("accumulator zero indication wrong");

	a_pc_clear: assert property (@(posedge pclk) disable iff (!presetn)
		only_clear |=> program_counter == PC_RESET)
		else $error("program counter not cleared");

	a_jump_load: assert property (@(posedge pclk) disable iff (!presetn)
		only_mb |=> program_counter == ($past(program_counter)
			| $past(memory_buffer_register[PC_LO:PC_HI])))
		else $error("jump address not loaded");

	a_ma_load: assert property (@(posedge pclk) disable iff (!presetn)
		only_ma |=> program_counter == ($past(program_counter)
			| $past(memory_address_register)))
		else $error("address register not loaded into pc");

	a_fetch_delay: assert property (@(posedge pclk) disable iff (!presetn)
		pc_to_ma |-> !fetch_inc_pending[INC_DELAY_CYCLES-1] ##2 pc_increment)
		else $error("fetch increment not two cycles after copy");

	a_skip_inc: assert property (@(posedge pclk) disable iff (!presetn)
		(t5 && operate_skip_level && !pc_clear && !pc_load_switches && !pc_load_mb
			&& !pc_load_ma) |=> program_counter == $past(program_counter) + 13'h0001)
		else $error("skip did not increment pc");

	a_pc_to_ma: assert property (@(posedge pclk) disable iff (!presetn)
		(t1 && fetch_state) |-> pc_to_ma && ma_load_data == program_counter)
		else $error("pc not copied to ma at fetch T1");

	a_switch_pc_load: assert property (@(posedge pclk) disable iff (!presetn)
		(pc_load_switches && !pc_clear && !pc_load_mb && !pc_load_ma && !pc_increment)
			|=> program_counter == ($past(program_counter) | $past(console_address_switches)))
		else $error("address switches not loaded into pc");

	a_pov_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!t1 && !pov_set) |=> possible_overflow_flag == $past(possible_overflow_flag))
		else $error("possible overflow flag changed without cause");

	a_link_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!tp1 |-> !link_set)
		else $error("link set outside TP1");

	a_skip_link: assert property (@(posedge pclk) disable iff (!presetn)
		(operate_instruction && !skip_invert && skip_select == 3'b100)
			|-> operate_skip_level == link_bit)
		else $error("link skip wrong");

	a_skip_empty: assert property (@(posedge pclk) disable iff (!presetn)
		(operate_instruction && skip_invert && skip_select == 3'b000) |-> operate_skip_level)
		else $error("empty inverted skip did not skip");

	a_skip_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!operate_instruction |-> !operate_skip_level)
		else $error("skip level outside operate");

	a_tape_inc: assert property (@(posedge pclk) disable iff (!presetn)
		(sp2 && read_tape && !pc_clear && !pc_load_switches && !pc_load_mb && !pc_load_ma)
			|=> program_counter == $past(program_counter) + 13'h0001)
		else $error("tape read did not increment pc");

	a_pc_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!pc_clear && !pc_load_switches && !pc_load_mb && !pc_load_ma && !pc_increment)
			|=> $stable(program_counter))
		else $error("pc changed without a command");

	a_opr_load_data: assert property (@(posedge pclk) disable iff (!presetn)
		opr_acs_load |-> ac_load_switches && ac_load_data == console_accumulator_switches)
		else $error("operate switch load missing");

	a_copy_first: assert property (@(posedge pclk) disable iff (!presetn)
		pc_to_ma |=> !fetch_inc_pending[INC_DELAY_CYCLES-1])
		else $error("fetch increment came before copy");

endmodule : pc_and_accumulator_control

`default_nettype wire

// file: dv/accumulator_link_model.sv
// accumulator and link registers of the processor datapath
`timescale 1ns/1ps
`default_nettype none

module accumulator_link_model
	import pc_ac_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ac_load_switches,
	input  wire logic [0:WORD_W-1] ac_load_data,
	input  wire logic              link_set,
	output logic      [0:WORD_W-1] accumulator_register,
	output logic                   link_bit
);
	// ****************************************************************
	// registers, loaded only on a command pulse
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator_register <= '0;
			link_bit             <= 1'b0;
		end else begin
			if (ac_load_switches) accumulator_register <= ac_load_data;
			if (link_set) link_bit <= 1'b1;
		end
	end
endmodule : accumulator_link_model
`default_nettype wire

// file: dv/pc_and_accumulator_control_bench.sv
// self-checking bench for the program counter and accumulator control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end

module pc_and_accumulator_control_bench
	import pc_ac_pkg::*;
;
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int T1 = 0, T3 = 1, T4 = 2, T5 = 3, T6 = 4, T7 = 5, TP1 = 6, SP1 = 7, SP2 = 8, SP4 = 9;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd_data;
	logic fetch_state = 0, execute_state = 0, break_state = 0, key_start = 0, key_examine = 0;
	logic key_deposit = 0, key_deposit_next = 0, readin = 0, repeat_flag = 0, read_tape = 0;
	logic operate_instruction = 0, jump_instruction = 0, subroutine_jump_instruction = 0;
	logic add_instruction = 0, rd_err, s_acl, s_ls, s_pm;
	logic [0:WORD_W-1] memory_buffer_register = '0, accumulator_register, ac_load_data;
	logic [PC_LO:PC_HI] memory_address_register = '0, ma_load_data, program_counter, s_ma, p;
	logic link_bit, ac_load_switches, link_set, pc_to_ma, possible_overflow_flag;
	logic add_overflow_level, operate_skip_level, ac_zero, ac_nonzero;
	logic [9:0] tp = '0;
	wire logic t1 = tp[0], t3 = tp[1], t4 = tp[2], t5 = tp[3], t6 = tp[4], t7 = tp[5];
	wire logic tp1 = tp[6], sp1 = tp[7], sp2 = tp[8], sp4 = tp[9];
	int fails = 0, checks = 0;

	pc_and_accumulator_control dut_u (.*);
	accumulator_link_model model_u (.*);
	always #5 pclk = ~pclk;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) fails++;
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 0; penable <= 0;
		#1;
	endtask : apb

	task automatic fire(input int i);
		@(posedge pclk);
		tp <= 10'(1) << i;
		#1;
		s_acl = ac_load_switches; s_ls = link_set; s_pm = pc_to_ma; s_ma = ma_load_data;
		@(posedge pclk);
		tp <= '0;
		#1;
	endtask : fire

	task automatic set_ac(input logic [17:0] v);
		apb(1, ACC_SWITCH_ADDR, {14'h0, v});
		key_deposit <= 1;
		fire(SP2);
		key_deposit <= 0;
		`CHK("ac_load", v, accumulator_register)
	endtask : set_ac

	task automatic skip_sweep();
		logic [17:0] ac;
		logic e;
		for (int a = 0; a < 3; a++) begin
			ac = (a == 0) ? 18'h00000 : (a == 1) ? 18'h20000 : 18'h00001;
			set_ac(ac);
			`CHK("ac_zero", ac == 0, ac_zero)
			`CHK("ac_nonzero", ac != 0, ac_nonzero)
			for (int s = 0; s < 16; s++) begin
				operate_instruction <= 1;
				memory_buffer_register <= 18'(s) << 6;
				#1;
				e = s[3] ? ((!s[2] | !link_bit) & (!s[1] | ac != 0) & (!s[0] | !ac[17]))
					: ((s[2] & link_bit) | (s[1] & ac == 0) | (s[0] & ac[17]));
				`CHK("skip", e, operate_skip_level)
				p = program_counter;
				fire(T5);
				`CHK("skip_pc", p + 13'(e), program_counter)
			end
			operate_instruction <= 0;
		end
		$display("skip sweep done");
	endtask : skip_sweep

	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		#500000;
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		apb(0, PC_ADDR, 0);
		`CHK("pc_reset", 32'h0, rd_data)
		apb(0, 8'hFC, 0);
		`CHK("unmapped", 1'b1, rd_err)
		key_deposit_next <= 1;
		apb(1, ACC_SWITCH_ADDR, 32'h2AAAA);
		fire(SP2);
		key_deposit_next <= 0;
		apb(0, ACCUM_ADDR, 0);
		`CHK("ac_read", 32'h2AAAA, rd_data)
		apb(1, ACC_SWITCH_ADDR, 32'h15555);
		operate_instruction <= 1;
		fire(T7);
		`CHK("no_acs", 1'b0, s_acl)
		memory_buffer_register <= 18'h00004;
		fire(T7);
		`CHK("acs_t7", 18'h15555, accumulator_register)
		operate_instruction <= 0;
		$display("accumulator test done");
		skip_sweep();
		apb(1, ADDR_SWITCH_ADDR, 32'h1ABC);
		key_start <= 1;
		fire(SP1);
		`CHK("pc_clear", 13'h0, program_counter)
		fire(SP2);
		`CHK("pc_switch", 13'h1ABC, program_counter)
		key_start <= 0; key_examine <= 1;
		fire(SP4);
		`CHK("pc_sp4", 13'h1ABD, program_counter)
		key_examine <= 0; read_tape <= 1;
		fire(SP2);
		`CHK("pc_tape", 13'h1ABE, program_counter)
		read_tape <= 0; readin <= 1; repeat_flag <= 1;
		fire(SP1);
		fire(SP2);
		`CHK("pc_rpt", 13'h1ABE, program_counter)
		repeat_flag <= 0;
		fire(SP1);
		`CHK("pc_rdin", 13'h0, program_counter)
		fire(SP2);
		`CHK("pc_rdsw", 13'h1ABC, program_counter)
		readin <= 0; fetch_state <= 1;
		fire(T1);
		`CHK("pc_to_ma", 1'b1, s_pm)
		`CHK("ma_data", 13'h1ABC, s_ma)
		`CHK("pc_hold", 13'h1ABC, program_counter)
		@(posedge pclk);
		@(posedge pclk);
		#1;
		`CHK("pc_fetch", 13'h1ABD, program_counter)
		jump_instruction <= 1; memory_buffer_register <= 18'h3F0F5;
		fire(T5);
		`CHK("jmp_clear", 13'h0, program_counter)
		fire(T6);
		`CHK("jmp_load", 13'h10F5, program_counter)
		jump_instruction <= 0; fetch_state <= 0; execute_state <= 1;
		subroutine_jump_instruction <= 1; memory_address_register <= 13'h0777;
		fire(T3);
		`CHK("jms_clear", 13'h0, program_counter)
		fire(T4);
		`CHK("jms_load", 13'h0777, program_counter)
		subroutine_jump_instruction <= 0; execute_state <= 0; break_state <= 1;
		memory_address_register <= 13'h0;
		fire(T3);
		fire(T4);
		`CHK("brk_load", 13'h0, program_counter)
		break_state <= 0;
		$display("program counter test done");
		set_ac(18'h20000);
		add_instruction <= 1; execute_state <= 1;
		fire(T4);
		`CHK("pov_none", 1'b0, possible_overflow_flag)
		memory_buffer_register <= 18'h20000;
		fire(TP1);
		`CHK("no_link", 1'b0, s_ls | link_bit)
		set_ac(18'h1FFFF);
		fire(T4);
		`CHK("pov_set", 1'b1, possible_overflow_flag)
		`CHK("ovf", 1'b1, add_overflow_level)
		fire(TP1);
		`CHK("link_set", 1'b1, s_ls & link_bit)
		fire(T1);
		`CHK("pov_clr", 1'b0, possible_overflow_flag)
		`CHK("ovf_off", 1'b0, add_overflow_level)
		add_instruction <= 0; execute_state <= 0;
		$display("overflow test done");
		skip_sweep();
		tally_and_finish();
	end
endmodule : pc_and_accumulator_control_bench
`default_nettype wire
